// >>> rtl/sst_pkg.sv
package sst_pkg;

   // Clock and control-loop tick timing, times in picoseconds
   localparam int CLK_PERIOD_PS = 5000;
   localparam int TICK_FAST_PS = 166670000;
   localparam int TICK_SLOW_PS = 500000000;
   localparam int TICK_FAST_CYC = TICK_FAST_PS / CLK_PERIOD_PS;
   localparam int TICK_SLOW_CYC = TICK_SLOW_PS / CLK_PERIOD_PS;
   // Longest timeout in ticks: 100 s fast, 300 s slow, both land here
   localparam logic [31:0] TMO_MAX_TICKS = 32'h000927C0;

   // Widths of the digital I/O and the storage depths
   localparam int DATA_W = 32;
   localparam int DIN_W = 10;
   localparam int DOUT_W = 4;
   localparam int PIN_W = 3;
   localparam int DIN_UNUSED_BIT = 7;
   localparam int DEPTH_N = 8;
   localparam int DEPTH_W = 3;
   localparam int MT_W = 8;
   localparam int SEL_W = 4;
   localparam int CODE_W = 8;
   localparam logic [DEPTH_W-1:0] DEPTH_LIVE = 3'h0;

   // Parameter indices on the parameter port
   localparam logic [SEL_W-1:0] PRM_IN_MASK = 4'h0;
   localparam logic [SEL_W-1:0] PRM_IN_PAT = 4'h1;
   localparam logic [SEL_W-1:0] PRM_OUT_MASK = 4'h2;
   localparam logic [SEL_W-1:0] PRM_OUT_PAT = 4'h3;
   localparam logic [SEL_W-1:0] PRM_TMO = 4'h4;
   localparam logic [SEL_W-1:0] PRM_CONCAT = 4'h5;
   localparam logic [SEL_W-1:0] PRM_PIN_STATE = 4'h6;
   localparam logic [SEL_W-1:0] PRM_STATUS = 4'h7;
   localparam logic [DATA_W-1:0] PRM_RESET = 32'h00000000;

   // Status word bit positions
   localparam int STS_ERR = 0;
   localparam int STS_WAIT = 1;
   localparam int STS_PEND = 2;
   localparam int STS_BUSY = 3;

   // Concatenation modes
   localparam logic [1:0] CONCAT_OFF = 2'h0;
   localparam logic [1:0] CONCAT_SCURVE = 2'h1;
   localparam logic [1:0] CONCAT_BF_ENDLESS = 2'h2;
   localparam logic [1:0] CONCAT_BF_SINGLE = 2'h3;

   // Movement types that take part in each mode
   localparam logic [MT_W-1:0] MT_SC_A = 8'h01;
   localparam logic [MT_W-1:0] MT_SC_B = 8'h11;
   localparam logic [MT_W-1:0] MT_SC_C = 8'h18;
   localparam logic [MT_W-1:0] MT_TB_A = 8'h03;
   localparam logic [MT_W-1:0] MT_TB_B = 8'h0A;
   localparam logic [MT_W-1:0] MT_TB_C = 8'h13;
   localparam logic [MT_W-1:0] MT_TB_D = 8'h1A;

   // Error codes
   localparam logic [CODE_W-1:0] ERR_NONE = 8'h00;
   localparam logic [CODE_W-1:0] ERR_SYNC_START = 8'h3F;

   typedef enum logic {ST_IDLE, ST_WAIT} sst_state_t;

endpackage : sst_pkg

// >>> rtl/sst_tick_div.sv
`timescale 1ns/1ps
// Control-loop tick divider: one-cycle enable every CYCLES clocks
module sst_tick_div import sst_pkg::*; #(
   parameter int CYCLES = TICK_FAST_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Tick enable
   output logic tick
);

   logic [31:0] cnt_q;
   logic wrap;

   // Wrap at the end of the period
   assign wrap = (cnt_q == 32'(CYCLES - 1));

   // Free-running period counter
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 32'h00000000;
         tick <= 1'b0;
      end else begin
         cnt_q <= wrap ? 32'h00000000 : cnt_q + 32'h00000001;
         tick <= wrap;
      end
   end

endmodule : sst_tick_div

// >>> rtl/sst_trigger.sv
`timescale 1ns/1ps
// How it works
// - Inputs form a mask, input n at bit n-1; bit 7 unused.
// - After sync start, hold movement until masked inputs equal the pattern.
// - When the synchronised move begins, masked outputs take the output pattern bits.
// - Outputs form a four-bit mask, output n at bit n-1.
// - Waiting longer than the timeout raises sync start error code 63.
// - Timeout counts control-loop ticks; limit clamps at the longest time.
// - Shared pins are driven high where their output-state bit is set, else stay inputs.
// - Mode 0 off, 1 S-curve concat, 2 endless and 3 single back-and-forth.
// - Without concatenation a new move waits until the current one ends.
// - Mode 1 replaces a running move at once with new limits when the movement type is S-curve.
// - A target at nonzero depth is only stored; depth 0 starts moving.
// - Starting a stored depth in mode 1 with an S-curve movement type interrupts the running move.
// - Any group axis failing sync start puts every axis still waiting for sync start in error.
module sst_trigger import sst_pkg::*; #(
   parameter int TICK_CYCLES = TICK_FAST_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Parameter port
   input wire logic prm_wr,
   input wire logic [SEL_W-1:0] prm_sel,
   input wire logic [DATA_W-1:0] prm_wdata,
   output logic [DATA_W-1:0] prm_rd_data_q,
   // Motion commands
   input wire logic sync_start_cmd,
   input wire logic stored_move_start_cmd,
   input wire logic pos_wr_cmd,
   input wire logic speed_limit_cmd,
   input wire logic accel_limit_cmd,
   input wire logic [DEPTH_W-1:0] cmd_depth,
   input wire logic [DATA_W-1:0] cmd_data,
   input wire logic [MT_W-1:0] movement_type,
   // Trajectory generator
   input wire logic move_busy,
   output logic move_start_q,
   output logic move_replace_q,
   output logic [DATA_W-1:0] tgt_pos_q,
   output logic [DATA_W-1:0] tgt_spd_q,
   output logic [DATA_W-1:0] tgt_acc_q,
   output logic bf_endless_q,
   output logic bf_single_q,
   // Digital inputs and outputs
   input wire logic [DIN_W-1:0] din,
   output logic [DOUT_W-1:0] dout_q,
   input wire logic [PIN_W-1:0] pin_in,
   output logic [PIN_W-1:0] pin_out_q,
   output logic [PIN_W-1:0] pin_oe_n_q,
   // Error and group
   input wire logic err_clr,
   input wire logic group_err_in,
   output logic group_err_out_q,
   output logic sync_wait_q,
   output logic [CODE_W-1:0] error_code_monitor_q
);

   // S-curve movement types
   function automatic logic is_scurve(input logic [MT_W-1:0] mt);
      is_scurve = (mt == MT_SC_A) || (mt == MT_SC_B) || (mt == MT_SC_C);
   endfunction : is_scurve

   // Table-driven movement types
   function automatic logic is_table(input logic [MT_W-1:0] mt);
      is_table = (mt == MT_TB_A) || (mt == MT_TB_B) || (mt == MT_TB_C) || (mt == MT_TB_D);
   endfunction : is_table

   logic [DATA_W-1:0] in_mask_q, in_pat_q, out_mask_q, out_pat_q, tmo_q, concat_q, pin_state_q;
   logic [DATA_W-1:0] mem_pos [DEPTH_N];
   logic [DATA_W-1:0] mem_spd [DEPTH_N];
   logic [DATA_W-1:0] mem_acc [DEPTH_N];
   logic [DIN_W-1:0] din_m_q, din_s_q;
   logic [PIN_W-1:0] pin_m_q, pin_s_q;
   logic grp_m_q, grp_s_q;
   logic [31:0] tmo_cnt_q;
   logic err_q, pend_q, tick;
   sst_state_t st_q, st_d;
   sst_tick_div #(.CYCLES(TICK_CYCLES)) u_tick (
      .clk(clk),
      .rst(rst),
      .tick(tick)
   );

   // Two-flop synchronisers for every pin input
   always_ff @(posedge clk) begin
      if (rst) begin
         {din_m_q, din_s_q, pin_m_q, pin_s_q, grp_m_q, grp_s_q} <= '0;
      end else begin
         din_m_q <= din;
         din_s_q <= din_m_q;
         pin_m_q <= pin_in;
         pin_s_q <= pin_m_q;
         grp_m_q <= group_err_in;
         grp_s_q <= grp_m_q;
      end
   end

   // Input image: a shared pin counts only while released as an input
   logic [DIN_W-1:0] din_eff;
   logic [DIN_W-1:0] din_shared, mask_eff;
   genvar gi;
   generate
      for (gi = 0; gi < DIN_W; gi++) begin : g_din
         if (gi < PIN_W) begin : g_sh
            assign din_shared[gi] = pin_s_q[gi] & ~pin_state_q[gi];
         end else begin : g_nsh
            assign din_shared[gi] = 1'b0;
         end
         if (gi == DIN_UNUSED_BIT) begin : g_unused
            assign din_eff[gi] = 1'b0;
            assign mask_eff[gi] = 1'b0;
         end else begin : g_used
            assign din_eff[gi] = din_s_q[gi] | din_shared[gi];
            assign mask_eff[gi] = in_mask_q[gi];
         end
      end
   endgenerate

   // Match, timeout and mode decode
   logic in_match, tmo_over, concat_ok, can_go, sync_go, err_set, grp_hit;
   logic depth_copy, pos_live, req_now;
   logic [31:0] tmo_lim;
   logic [1:0] mode;
   assign mode = concat_q[1:0];
   assign in_match = ((din_eff ^ in_pat_q[DIN_W-1:0]) & mask_eff) == '0;
   assign tmo_lim = (tmo_q > TMO_MAX_TICKS) ? TMO_MAX_TICKS : tmo_q;
   assign tmo_over = (tmo_cnt_q > tmo_lim);
   assign concat_ok = (mode == CONCAT_SCURVE) && is_scurve(movement_type);
   assign can_go = ~move_busy | concat_ok;
   assign grp_hit = grp_s_q & (st_q == ST_WAIT);
   assign sync_go = (st_q == ST_WAIT) && in_match && can_go && !tmo_over && !grp_s_q;
   assign err_set = (st_q == ST_WAIT) && !sync_go && (tmo_over || grp_hit);
   assign depth_copy = sync_start_cmd | stored_move_start_cmd;
   assign pos_live = pos_wr_cmd && (cmd_depth == DEPTH_LIVE);
   assign req_now = pos_live | stored_move_start_cmd;

   // Sync-start sequencer
   always_comb begin
      case (st_q)
         ST_IDLE: st_d = sync_start_cmd ? ST_WAIT : ST_IDLE;
         ST_WAIT: st_d = (sync_go || err_set) ? ST_IDLE : ST_WAIT;
         default: st_d = ST_IDLE;
      endcase
   end

   // Parameters written by the host
   always_ff @(posedge clk) begin
      if (rst) begin
         {in_mask_q, in_pat_q, out_mask_q, out_pat_q, tmo_q, concat_q} <= {6{PRM_RESET}};
      end else if (prm_wr) begin
         case (prm_sel)
            PRM_IN_MASK: in_mask_q <= prm_wdata;
            PRM_IN_PAT: in_pat_q <= prm_wdata;
            PRM_OUT_MASK: out_mask_q <= prm_wdata;
            PRM_OUT_PAT: out_pat_q <= prm_wdata;
            PRM_TMO: tmo_q <= prm_wdata;
            PRM_CONCAT: concat_q <= prm_wdata;
            default: ;
         endcase
      end
   end

   // Depth storage: a start copies its depth into the live slot
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < DEPTH_N; i++) begin
            mem_pos[i] <= PRM_RESET;
            mem_spd[i] <= PRM_RESET;
            mem_acc[i] <= PRM_RESET;
         end
      end else if (depth_copy) begin
         mem_pos[DEPTH_LIVE] <= mem_pos[cmd_depth];
         mem_spd[DEPTH_LIVE] <= mem_spd[cmd_depth];
         mem_acc[DEPTH_LIVE] <= mem_acc[cmd_depth];
      end else begin
         if (pos_wr_cmd) begin
            mem_pos[cmd_depth] <= cmd_data;
         end
         if (speed_limit_cmd) begin
            mem_spd[cmd_depth] <= cmd_data;
         end
         if (accel_limit_cmd) begin
            mem_acc[cmd_depth] <= cmd_data;
         end
      end
   end

   // Start requests wait one cycle so the live slot is settled
   logic fire;
   assign fire = (pend_q | sync_go) & can_go;
   // Sequencer, timeout counter and movement launch
   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= ST_IDLE;
         tmo_cnt_q <= 32'h00000000;
         {pend_q, move_start_q, move_replace_q} <= 3'h0;
         {tgt_pos_q, tgt_spd_q, tgt_acc_q} <= {3{PRM_RESET}};
      end else begin
         st_q <= st_d;
         if (sync_start_cmd) begin
            tmo_cnt_q <= 32'h00000000;
         end else if (st_q == ST_WAIT && tick && !sync_go && !err_set) begin
            tmo_cnt_q <= tmo_cnt_q + 32'h00000001;
         end
         pend_q <= req_now | (pend_q & ~fire);
         move_start_q <= fire;
         move_replace_q <= fire & move_busy;
         if (fire) begin
            tgt_pos_q <= mem_pos[DEPTH_LIVE];
            tgt_spd_q <= mem_spd[DEPTH_LIVE];
            tgt_acc_q <= mem_acc[DEPTH_LIVE];
         end
      end
   end

   // Outputs: masked pattern applied when a synchronised move begins
   logic [DOUT_W-1:0] dout_next;
   logic [PIN_W-1:0] pin_next;
   assign dout_next = (dout_q & ~out_mask_q[DOUT_W-1:0]) |
                      (out_pat_q[DOUT_W-1:0] & out_mask_q[DOUT_W-1:0]);
   assign pin_next = (pin_state_q[PIN_W-1:0] & ~out_mask_q[PIN_W-1:0]) |
                     (out_pat_q[PIN_W-1:0] & out_mask_q[PIN_W-1:0]);
   always_ff @(posedge clk) begin
      if (rst) begin
         dout_q <= '0;
         pin_state_q <= PRM_RESET;
      end else if (sync_go) begin
         dout_q <= dout_next;
         pin_state_q <= {pin_state_q[DATA_W-1:PIN_W], pin_next};
      end else if (prm_wr && prm_sel == PRM_PIN_STATE) begin
         pin_state_q <= prm_wdata;
      end
   end

   // Shared pins drive only where the state bit is set, else stay inputs
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_out_q <= '0;
         pin_oe_n_q <= '1;
      end else begin
         pin_out_q <= pin_state_q[PIN_W-1:0];
         pin_oe_n_q <= ~pin_state_q[PIN_W-1:0];
      end
   end

   // Sticky error; a new error beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         {err_q, group_err_out_q} <= 2'h0;
         error_code_monitor_q <= ERR_NONE;
      end else begin
         if (err_set) begin
            err_q <= 1'b1;
            error_code_monitor_q <= ERR_SYNC_START;
         end else if (err_clr) begin
            err_q <= 1'b0;
            error_code_monitor_q <= ERR_NONE;
         end
         group_err_out_q <= err_set | (err_q & ~err_clr);
      end
   end

   // Status, mode flags and readback
   logic [DATA_W-1:0] status_w, rd_mux;
   assign status_w = DATA_W'({move_busy, pend_q, st_q == ST_WAIT, err_q});
   always_comb begin
      case (prm_sel)
         PRM_IN_MASK: rd_mux = in_mask_q;
         PRM_IN_PAT: rd_mux = in_pat_q;
         PRM_OUT_MASK: rd_mux = out_mask_q;
         PRM_OUT_PAT: rd_mux = out_pat_q;
         PRM_TMO: rd_mux = tmo_q;
         PRM_CONCAT: rd_mux = concat_q;
         PRM_PIN_STATE: rd_mux = pin_state_q;
         PRM_STATUS: rd_mux = status_w;
         default: rd_mux = PRM_RESET;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         {prm_rd_data_q, bf_endless_q, bf_single_q, sync_wait_q} <= {PRM_RESET, 3'h0};
      end else begin
         prm_rd_data_q <= rd_mux;
         bf_endless_q <= (mode == CONCAT_BF_ENDLESS) && is_table(movement_type);
         bf_single_q <= (mode == CONCAT_BF_SINGLE) && is_table(movement_type);
         sync_wait_q <= (st_d == ST_WAIT);
      end
   end

   // Checks
   property p_bit7_ignored;
      @(posedge clk) disable iff (rst) (st_q == ST_WAIT &&
         in_mask_q[DIN_W-1:0] == (DIN_W'(1) << DIN_UNUSED_BIT)) |-> in_match;
   endproperty
   a_bit7_ignored: assert property (p_bit7_ignored) else $error("bit 7 blocked start");
   property p_go_needs_match;
      @(posedge clk) disable iff (rst) sync_go |-> in_match && st_q == ST_WAIT;
   endproperty
   a_go_needs_match: assert property (p_go_needs_match) else $error("no match at start");
   property p_dout_pattern;
      @(posedge clk) disable iff (rst) sync_go |=> ((dout_q & out_mask_q[DOUT_W-1:0]) ==
         (out_pat_q[DOUT_W-1:0] & out_mask_q[DOUT_W-1:0])) ##1 move_start_q == 1'b0;
   endproperty
   a_dout_pattern: assert property (p_dout_pattern) else $error("outputs miss pattern");
   property p_err_code;
      @(posedge clk) disable iff (rst) err_set |=> err_q && error_code_monitor_q == ERR_SYNC_START
         && st_q == ST_IDLE;
   endproperty
   a_err_code: assert property (p_err_code) else $error("timeout code wrong");
   property p_cnt_clear;
      @(posedge clk) disable iff (rst) sync_start_cmd |=> tmo_cnt_q == 32'h00000000;
   endproperty
   a_cnt_clear: assert property (p_cnt_clear) else $error("timeout counter not cleared");
   property p_deep_store;
      @(posedge clk) disable iff (rst) (pos_wr_cmd && cmd_depth != DEPTH_LIVE && !pend_q
         && !stored_move_start_cmd && !sync_go) |=> !move_start_q;
   endproperty
   a_deep_store: assert property (p_deep_store) else $error("stored target moved motor");
   property p_in_order;
      @(posedge clk) disable iff (rst) (pend_q && move_busy && !concat_ok) |=> !move_start_q;
   endproperty
   a_in_order: assert property (p_in_order) else $error("move started while busy");
   property p_replace;
      @(posedge clk) disable iff (rst) (pend_q && move_busy && concat_ok) |=>
         move_start_q && move_replace_q && tgt_pos_q == $past(mem_pos[DEPTH_LIVE]);
   endproperty
   a_replace: assert property (p_replace) else $error("concatenated move not taken");
   property p_group;
      @(posedge clk) disable iff (rst) (grp_s_q && st_q == ST_WAIT) |=> err_q ##1 group_err_out_q;
   endproperty
   a_group: assert property (p_group) else $error("group error ignored");

endmodule : sst_trigger

// >>> bench/sst_host_model.sv
`timescale 1ns/1ps
// Stand-in for the trajectory generator and the world on the shared pins
module sst_host_model import sst_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Motion side
   input wire logic move_start_q,
   input wire logic [7:0] busy_len,
   output logic move_busy,
   // Shared pins
   input wire logic [PIN_W-1:0] pin_out_q,
   input wire logic [PIN_W-1:0] pin_oe_n_q,
   input wire logic [PIN_W-1:0] pin_ext,
   output logic [PIN_W-1:0] pin_in
);
   logic [7:0] cnt_q;

   // Any start, replacing or not, reloads the remaining move time
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 8'h00;
      end else if (move_start_q) begin
         cnt_q <= busy_len;
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
   assign move_busy = (cnt_q != 8'h00);

   // The outside drives only released pins, so no pin is fought over
   assign pin_in = (pin_out_q & ~pin_oe_n_q) | (pin_ext & pin_oe_n_q);
endmodule : sst_host_model

// >>> bench/sync_start_trigger_tb.sv
`timescale 1ns/1ps
// Self-checking bench; short tick period keeps the timeout scenarios fast
module sync_start_trigger_tb import sst_pkg::*; ();
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic prm_wr = 1'b0;
   logic [SEL_W-1:0] prm_sel = 4'h0;
   logic [DATA_W-1:0] prm_wdata = 32'h0;
   logic sync_start_cmd = 1'b0;
   logic stored_move_start_cmd = 1'b0;
   logic pos_wr_cmd = 1'b0;
   logic speed_limit_cmd = 1'b0;
   logic accel_limit_cmd = 1'b0;
   logic [DEPTH_W-1:0] cmd_depth = 3'h0;
   logic [DATA_W-1:0] cmd_data = 32'h0;
   logic [MT_W-1:0] movement_type = MT_SC_A;
   logic [DIN_W-1:0] din = 10'h000;
   logic [PIN_W-1:0] pin_ext = 3'h0;
   logic err_clr = 1'b0;
   logic group_err_in = 1'b0;
   logic [7:0] busy_len = 8'h14;
   logic [DATA_W-1:0] prm_rd_data_q, tgt_pos_q, tgt_spd_q, tgt_acc_q;
   logic move_busy, move_start_q, move_replace_q, bf_endless_q, bf_single_q;
   logic [DOUT_W-1:0] dout_q;
   logic [PIN_W-1:0] pin_in, pin_out_q, pin_oe_n_q;
   logic group_err_out_q, sync_wait_q;
   logic [CODE_W-1:0] error_code_monitor_q;
   int err_count = 0;
   int comparisons = 0;
   int n;

   // Clock
   always #2.5 clk = ~clk;

   sst_trigger #(.TICK_CYCLES(4)) dut (
      .clk(clk), .rst(rst), .prm_wr(prm_wr), .prm_sel(prm_sel), .prm_wdata(prm_wdata),
      .prm_rd_data_q(prm_rd_data_q), .sync_start_cmd(sync_start_cmd),
      .stored_move_start_cmd(stored_move_start_cmd), .pos_wr_cmd(pos_wr_cmd),
      .speed_limit_cmd(speed_limit_cmd), .accel_limit_cmd(accel_limit_cmd),
      .cmd_depth(cmd_depth), .cmd_data(cmd_data), .movement_type(movement_type),
      .move_busy(move_busy), .move_start_q(move_start_q), .move_replace_q(move_replace_q),
      .tgt_pos_q(tgt_pos_q), .tgt_spd_q(tgt_spd_q), .tgt_acc_q(tgt_acc_q),
      .bf_endless_q(bf_endless_q), .bf_single_q(bf_single_q), .din(din), .dout_q(dout_q),
      .pin_in(pin_in), .pin_out_q(pin_out_q), .pin_oe_n_q(pin_oe_n_q), .err_clr(err_clr),
      .group_err_in(group_err_in), .group_err_out_q(group_err_out_q),
      .sync_wait_q(sync_wait_q), .error_code_monitor_q(error_code_monitor_q));

   sst_host_model host (
      .clk(clk), .rst(rst), .move_start_q(move_start_q), .busy_len(busy_len),
      .move_busy(move_busy), .pin_out_q(pin_out_q), .pin_oe_n_q(pin_oe_n_q),
      .pin_ext(pin_ext), .pin_in(pin_in));

   // Wide enough for a whole target triple compared in one go
   task chk(input logic [95:0] got, input logic [95:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task wr(input logic [3:0] s, input logic [31:0] d);
      @(posedge clk);
      prm_wr <= 1'b1;
      prm_sel <= s;
      prm_wdata <= d;
      @(posedge clk);
      prm_wr <= 1'b0;
   endtask : wr

   task rd(input logic [3:0] s, input logic [31:0] e);
      @(posedge clk);
      prm_sel <= s;
      repeat (3) @(posedge clk);
      #1;
      chk(prm_rd_data_q, e);
   endtask : rd

   // One-cycle command pulse; kind 0 pos, 1 speed, 2 accel, 3 stored start, 4 sync
   task cmd(input int k, input logic [2:0] d, input logic [31:0] v);
      @(posedge clk);
      cmd_depth <= d;
      cmd_data <= v;
      case (k)
         0: pos_wr_cmd <= 1'b1;
         1: speed_limit_cmd <= 1'b1;
         2: accel_limit_cmd <= 1'b1;
         3: stored_move_start_cmd <= 1'b1;
         default: sync_start_cmd <= 1'b1;
      endcase
      @(posedge clk);
      {pos_wr_cmd, speed_limit_cmd, accel_limit_cmd} <= 3'h0;
      {stored_move_start_cmd, sync_start_cmd} <= 2'h0;
   endtask : cmd

   // Counts edges until a start pulse, giving up after lim
   task wait_start(input int lim, output int c);
      c = 0;
      do begin
         @(posedge clk);
         #1;
         c++;
      end while (move_start_q !== 1'b1 && c < lim);
   endtask : wait_start

   task wait_err(input int lim, output int c);
      c = 0;
      do begin
         @(posedge clk);
         #1;
         c++;
      end while (error_code_monitor_q !== ERR_SYNC_START && c < lim);
   endtask : wait_err

   task idle_clear;
      for (int i = 0; i < 80 && move_busy !== 1'b0; i++) @(posedge clk);
      @(posedge clk);
      err_clr <= 1'b1;
      @(posedge clk);
      err_clr <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(error_code_monitor_q, ERR_NONE);
   endtask : idle_clear

   task t_prm;
      logic [31:0] v[7];
      v = '{32'h201, 32'h200, 32'hF, 32'h2, 32'h3, 32'h0, 32'h0};
      for (int i = 0; i < 7; i++) wr(i[3:0], v[i]);
      for (int i = 0; i < 7; i++) rd(i[3:0], v[i]);
      wr(4'h7, 32'hFFFFFFFF);
      rd(4'h7, 32'h0);
      wr(4'h9, 32'hA5A5A5A5);
      rd(4'h9, 32'h0);
   endtask : t_prm

   task t_move;
      cmd(1, 3'h1, 32'h44);
      cmd(2, 3'h1, 32'h55);
      cmd(0, 3'h1, 32'h66);
      wait_start(6, n);
      chk(move_start_q, 1'b0);
      cmd(0, 3'h0, 32'h77);
      wait_start(4, n);
      chk(n, 1);
      chk(tgt_pos_q, 32'h77);
      cmd(3, 3'h1, 32'h0);
      wait_start(40, n);
      chk(n > 10, 1'b1);
      chk(move_replace_q, 1'b0);
      chk({tgt_pos_q, tgt_spd_q, tgt_acc_q}, {32'h66, 32'h44, 32'h55});
   endtask : t_move

   task t_concat;
      wr(PRM_CONCAT, 32'h1);
      idle_clear();
      cmd(1, 3'h2, 32'h88);
      cmd(2, 3'h2, 32'h99);
      cmd(0, 3'h2, 32'hAA);
      cmd(0, 3'h0, 32'hBB);
      wait_start(4, n);
      cmd(3, 3'h2, 32'h0);
      wait_start(4, n);
      chk(n, 1);
      chk(move_replace_q, 1'b1);
      chk({tgt_pos_q, tgt_spd_q, tgt_acc_q}, {32'hAA, 32'h88, 32'h99});
   endtask : t_concat

   task t_sync;
      wr(PRM_TMO, 32'h64);
      wr(PRM_CONCAT, 32'h0);
      // Bit 7 is selected and wanted high, yet must not hold the start
      wr(PRM_IN_MASK, 32'h281);
      wr(PRM_IN_PAT, 32'h280);
      idle_clear();
      @(posedge clk);
      din <= 10'h081;
      cmd(4, 3'h0, 32'h0);
      wait_start(10, n);
      chk(sync_wait_q, 1'b1);
      chk({move_start_q, dout_q}, 5'h00);
      @(posedge clk);
      din <= 10'h200;
      wait_start(12, n);
      chk(move_start_q, 1'b1);
      chk(dout_q, 4'h2);
      repeat (2) @(posedge clk);
      #1;
      chk(sync_wait_q, 1'b0);
      wr(PRM_PIN_STATE, 32'h5);
      repeat (3) @(posedge clk);
      #1;
      chk({pin_out_q, pin_oe_n_q}, 6'h2A);
   endtask : t_sync

   task t_tmo;
      wr(PRM_TMO, 32'h3);
      din <= 10'h000;
      cmd(4, 3'h0, 32'h0);
      repeat (10) @(posedge clk);
      cmd(4, 3'h0, 32'h0);
      wait_err(60, n);
      chk(n >= 12 && n <= 22, 1'b1);
      chk({group_err_out_q, sync_wait_q}, 2'h2);
      idle_clear();
      wr(PRM_TMO, 32'h64);
      cmd(4, 3'h0, 32'h0);
      repeat (3) @(posedge clk);
      group_err_in <= 1'b1;
      wait_err(8, n);
      chk(n <= 6, 1'b1);
      @(posedge clk);
      group_err_in <= 1'b0;
      idle_clear();
   endtask : t_tmo

   task t_modes;
      @(posedge clk);
      movement_type <= MT_TB_A;
      for (int m = 0; m < 4; m++) begin
         wr(PRM_CONCAT, m);
         repeat (3) @(posedge clk);
         #1;
         chk({bf_endless_q, bf_single_q}, {m == 2, m == 3});
      end
   endtask : t_modes

   task end_of_test;
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test

   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(pin_oe_n_q, 3'h7);
      t_prm();
      t_move();
      t_concat();
      t_sync();
      t_tmo();
      t_modes();
      end_of_test();
   end

   // Watchdog, far beyond the few hundred cycles the scenarios need
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_of_test();
   end
endmodule : sync_start_trigger_tb
